// >>> iba_pkg.sv
// Package: timing constants, control bits and carrier structs of the arbiter
package iba_pkg;

    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam logic [1:0]  RAM_CYC      = 2'h1;
    localparam logic [1:0]  SYS_RD_CYC   = 2'h2;
    localparam logic [1:0]  SYS_WR_CYC   = 2'h3;
    localparam logic [1:0]  PER_RD_CYC   = 2'h2;
    localparam logic [1:0]  PER_WR_CYC   = 2'h3;
    localparam logic [1:0]  PBUF_WR_CYC  = 2'h2;
    localparam logic [1:0]  ALONE_CYC    = 2'h2;
    localparam logic [3:0]  PDIV_RST     = 4'h1;

    // Access space of an internal access
    typedef enum logic [2:0] {
        SP_RAM   = 3'b000,
        SP_SYS   = 3'b001,
        SP_PSLOW = 3'b010,
        SP_PBUF  = 3'b011,
        SP_EXT   = 3'b100
    } iba_space_e;

    // Bus control bits
    typedef struct packed {
        logic release_enable_bit;
        logic reclaim_output_enable;
        logic ext_write_buffer_enable;
        logic periph_write_buffer_enable;
        logic alternate_select_bit;
    } iba_ctrl_s;

    // One master's request
    typedef struct packed {
        logic       req;
        logic       wr;
        logic       lock;
        iba_space_e space;
    } iba_req_s;

endpackage

// >>> iba_cnt.sv
// Cycle counter that retires an access after a loaded number of ticks
`timescale 1ns/10ps
`default_nettype none
module iba_cnt
    import iba_pkg::*;
(
    input  wire logic       clock,  // System clock
    input  wire logic       rst_n,  // Async reset, low
    input  wire logic       load,   // Start a count
    input  wire logic [1:0] len,    // Ticks to count
    input  wire logic       tick,   // Count enable
    output logic            busy,   // Count running
    output logic            last,   // Final tick now
    output logic [1:0]      done_n  // Ticks already counted
);
    logic [1:0] rem_q;
    logic [1:0] cnt_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rem_q <= 2'h0;
            cnt_q <= 2'h0;
        end else if (load) begin
            rem_q <= len;
            cnt_q <= 2'h0;
        end else if (busy && tick) begin
            rem_q <= rem_q - 2'h1;
            cnt_q <= cnt_q + 2'h1;
        end
    end

    assign busy   = (rem_q != 2'h0);
    assign last   = busy && tick && (rem_q == 2'h1);
    assign done_n = cnt_q;
endmodule // iba_cnt
`default_nettype wire

// >>> iba_arbiter.sv
// Internal and external bus arbiter with access timing and write buffers
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module iba_arbiter
    import iba_pkg::*;
(
    input  wire logic      clock,          // System clock, 10 MHz
    input  wire logic      rst_n,          // Async reset, low
    input  wire logic      psel,           // APB select
    input  wire logic      penable,        // APB enable
    input  wire logic      pwrite,         // APB direction
    input  wire logic [7:0] paddr,         // APB byte address
    input  wire logic [31:0] pwdata,       // APB write data
    output logic [31:0]    prdata,         // APB read data
    output logic           pready,         // APB ready
    output logic           pslverr,        // APB error
    input  wire logic [3:0] periph_div,    // Peripheral divide n
    input  wire iba_req_s  cpu_req,        // Core request
    input  wire iba_req_s  dtc_req,        // Controller request
    input  wire logic      dtc_no_yield,   // Info read/first xfer/writeback
    input  wire logic      cpu_sleep,      // Core in sleep
    input  wire logic      stby_req,       // Standby or clock-stop request
    input  wire logic      clk_chg_req,    // Clock change request
    input  wire logic      sw_standby,     // In software standby
    input  wire logic      all_clk_stop,   // In all-module-clock-stop
    input  wire logic      pin_input_buffer_enable, // Pin input buffer on
    input  wire logic      ext_release_request_in,  // Release request pin, low
    input  wire logic      ext_cycle_busy, // External cycle running
    output logic           cpu_ack,        // Internal grant to core
    output logic           dtc_ack,        // Internal grant to controller
    output logic           ext_ack,        // External arbiter grant
    output logic           acc_done,       // Internal access retires
    output logic           stby_go,        // Deferred standby allowed
    output logic           clk_chg_go,     // Deferred clock change allowed
    output logic           release_ack_n_o,  // Acknowledge pin out
    output logic           release_ack_oe,   // Acknowledge pin drive
    output logic           bus_reclaim_request_out_o,  // Reclaim pin out
    output logic           bus_reclaim_request_out_oe, // Reclaim pin drive
    output logic           ext_bus_oe      // Address/data/control drive
);
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;

    iba_ctrl_s ctrl_q;
    logic      rel_s1_q, rel_s2_q;
    logic      released_q;
    logic      owner_dtc_q;
    logic      alt_turn_q;
    logic [3:0] pdiv_cnt_q;
    logic      pen;
    iba_req_s  win;
    logic      grant_cpu, grant_dtc;
    logic      start;
    logic      busy, last, pbusy, plast, xbusy;
    logic [1:0] len, done_n, pdone, xdone;
    logic      tick;
    logic      use_pbuf, use_xbuf;
    logic      rel_req;
    logic      ext_need;
    logic      per_q;
    logic      ld_main;

    // APB slave, zero wait states
    assign pready  = 1'b1;
    assign pslverr = psel && !((paddr == ADDR_CTRL) || (paddr == ADDR_STAT));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0;
        end else if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
            ctrl_q <= pwdata[4:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == ADDR_CTRL) begin
                prdata <= {27'h0, ctrl_q};
            end else if (paddr == ADDR_STAT) begin
                prdata <= {28'h0, released_q, owner_dtc_q, busy, xbusy};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // Peripheral clock enable, one pulse every n system cycles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pdiv_cnt_q <= PDIV_RST;
        end else if (pdiv_cnt_q >= periph_div || periph_div == 4'h0) begin
            pdiv_cnt_q <= PDIV_RST;
        end else begin
            pdiv_cnt_q <= pdiv_cnt_q + 4'h1;
        end
    end
    assign pen = (pdiv_cnt_q >= periph_div) || (periph_div <= 4'h1);

    // Release request pin synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rel_s1_q <= 1'b1;
            rel_s2_q <= 1'b1;
        end else begin
            rel_s1_q <= ext_release_request_in;
            rel_s2_q <= rel_s1_q;
        end
    end

    // Forwarded only when enabled, not in standby or clock stop
    assign rel_req = !rel_s2_q && ctrl_q.release_enable_bit
                   && pin_input_buffer_enable
                   && !sw_standby && !all_clk_stop;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            released_q <= 1'b0;
        end else if (!released_q && rel_req && !ext_cycle_busy && !xbusy) begin
            released_q <= 1'b1;
        end else if (released_q && rel_s2_q) begin
            released_q <= 1'b0;
        end
    end

    // Internal arbitration
    always_comb begin
        grant_dtc = 1'b0;
        grant_cpu = 1'b0;
        if (dtc_req.req && !(ctrl_q.alternate_select_bit && alt_turn_q
                             && cpu_req.req)) begin
            grant_dtc = 1'b1;
        end else if (cpu_req.req) begin
            grant_cpu = 1'b1;
        end
    end

    // Owner changes only when the holder may yield
    assign start = !busy && (grant_cpu || grant_dtc)
                 && !(owner_dtc_q && dtc_no_yield && dtc_req.req && grant_cpu)
                 && !(!owner_dtc_q && cpu_req.lock && grant_dtc);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            owner_dtc_q <= 1'b0;
            alt_turn_q  <= 1'b0;
        end else if (start) begin
            owner_dtc_q <= grant_dtc;
            alt_turn_q  <= grant_dtc;
        end
    end

    always_comb begin
        win = grant_dtc ? dtc_req : cpu_req;
        if (start && !grant_dtc && cpu_req.lock && owner_dtc_q && busy) begin
            win = cpu_req;
        end
    end

    // External access waits while released; release ranks above
    assign ext_need = win.req && win.space == SP_EXT;
    assign ext_ack  = start && ext_need && !released_q && !rel_req;
    assign cpu_ack  = grant_cpu && start && (!ext_need || ext_ack);
    assign dtc_ack  = grant_dtc && start && (!ext_need || ext_ack);

    // Buffered writes: counted in their own counter, main path free at once
    assign use_xbuf = ctrl_q.ext_write_buffer_enable && win.wr
                    && win.space == SP_EXT;
    assign use_pbuf = ctrl_q.periph_write_buffer_enable && win.wr
                    && win.space == SP_PBUF;

    always_comb begin
        unique case (win.space)
            SP_RAM:   len = RAM_CYC;
            SP_SYS:   len = win.wr ? SYS_WR_CYC : SYS_RD_CYC;
            SP_PSLOW: len = win.wr ? PER_WR_CYC : PER_RD_CYC;
            SP_PBUF:  len = win.wr ? PBUF_WR_CYC : PER_RD_CYC;
            default:  len = ALONE_CYC;
        endcase
    end

    assign ld_main = (cpu_ack || dtc_ack) && !use_pbuf && !use_xbuf;

    // Space of the access in flight, not of the next request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            per_q <= 1'b0;
        end else if (ld_main) begin
            per_q <= (win.space == SP_PSLOW) || (win.space == SP_PBUF);
        end
    end

    // Peripheral spaces count peripheral enables, giving 0..n-1 sync
    assign tick = per_q ? pen : 1'b1;

    iba_cnt u_main (
        .clock  (clock),
        .rst_n  (rst_n),
        .load   (ld_main),
        .len    (len),
        .tick   (tick),
        .busy   (busy),
        .last   (last),
        .done_n (done_n)
    );

    // Peripheral write buffer, counts two peripheral enables; main path never loaded
    iba_cnt u_pbuf (
        .clock  (clock),
        .rst_n  (rst_n),
        .load   ((cpu_ack || dtc_ack) && use_pbuf && !pbusy),
        .len    (PBUF_WR_CYC),
        .tick   (pen),
        .busy   (pbusy),
        .last   (plast),
        .done_n (pdone)
    );

    // External write buffer
    iba_cnt u_xbuf (
        .clock  (clock),
        .rst_n  (rst_n),
        .load   ((cpu_ack || dtc_ack) && use_xbuf && !xbusy),
        .len    (ALONE_CYC),
        .tick   (1'b1),
        .busy   (xbusy),
        .last   (),
        .done_n (xdone)
    );

    assign acc_done = last || plast;

    // Deferred transitions until bus recovered
    assign stby_go    = stby_req && !released_q;
    assign clk_chg_go = clk_chg_req && !released_q;

    // Pins: float in standby drive low when released
    assign release_ack_n_o = !released_q;
    assign release_ack_oe  = !sw_standby;
    assign ext_bus_oe      = !released_q;

    // Reclaim request
    assign bus_reclaim_request_out_o  = !(released_q
        && ctrl_q.reclaim_output_enable
        && ((win.req && win.space == SP_EXT) || stby_req || clk_chg_req));
    assign bus_reclaim_request_out_oe = !sw_standby;

    // Reset state handled by async reset of every register

    a_ram_one: assert property (@(posedge clock) disable iff (!rst_n)
        (cpu_ack || dtc_ack) && win.space == SP_RAM && !use_pbuf
        |=> last) else $error("ram access not one cycle");

    a_dtc_prio: assert property (@(posedge clock) disable iff (!rst_n)
        dtc_req.req && cpu_req.req && !ctrl_q.alternate_select_bit
        |-> !cpu_ack) else $error("core granted over controller");

    a_one_ack: assert property (@(posedge clock) disable iff (!rst_n)
        !(cpu_ack && dtc_ack)) else $error("two grants");

    a_rel_prio: assert property (@(posedge clock) disable iff (!rst_n)
        rel_req |-> !ext_ack) else $error("external access over release");

    a_no_rel_cyc: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(released_q) |-> !$past(ext_cycle_busy))
        else $error("release during external cycle");

    a_float_rel: assert property (@(posedge clock) disable iff (!rst_n)
        released_q |-> !ext_bus_oe && !release_ack_n_o)
        else $error("bus driven while released");

    a_stby_float: assert property (@(posedge clock) disable iff (!rst_n)
        sw_standby |-> !release_ack_oe && !bus_reclaim_request_out_oe)
        else $error("pins driven in standby");

    a_stby_defer: assert property (@(posedge clock) disable iff (!rst_n)
        released_q |-> !stby_go && !clk_chg_go)
        else $error("standby while released");

    a_sys_write: assert property (@(posedge clock) disable iff (!rst_n)
        (cpu_ack || dtc_ack) && win.space == SP_SYS && win.wr
        |=> busy ##1 busy ##1 busy ##1 !busy)
        else $error("system write length");
endmodule // iba_arbiter
`default_nettype wire

// >>> iba_ext_master.sv
// Model of the outside bus master that asks for the external bus
`timescale 1ns/10ps
`default_nettype none
module iba_ext_master #(
    parameter int LAG = 2  // Wait cycles; pin goes low LAG+1 cycles after wish
) (
    input  wire logic clock,  // System clock
    input  wire logic want,   // Bench wants the bus
    output var logic  req_n   // Release request pin, low active
);
    int lag_q;

    initial req_n = 1'b1;
    initial lag_q = 0;

    always @(posedge clock) begin
        if (!want) begin
            lag_q <= 0;
            req_n <= 1'b1;  // Pin back high ends the release
        end else if (lag_q < LAG) begin
            lag_q <= lag_q + 1;
        end else begin
            req_n <= 1'b0;  // Pin held low asks for release
        end
    end
endmodule // iba_ext_master
`default_nettype wire

// >>> iba_arbiter_tb_top.sv
// Self-checking bench of the bus arbiter
`timescale 1ns/10ps
`default_nettype none
module iba_arbiter_tb_top;
    import iba_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er;
    logic [3:0]  periph_div = 4'h1;
    iba_req_s    cpu_req = '0;
    iba_req_s    dtc_req = '0;
    logic        stby_req = 1'b0;
    logic        sw_standby = 1'b0;
    logic        pin_ibe = 1'b0;
    logic        want = 1'b0;
    logic        ext_busy = 1'b0;
    logic        req_n, cpu_ack, dtc_ack, acc_done, stby_go;
    logic        ack_n, ack_oe, rcl_n, rcl_oe, bus_oe;
    int          errors = 0;
    int          num_checks = 0;
    int          cyc = 0, dn = -1, cpu_acks = 0, dtc_acks = 0;
    int          cpu_at = 0, dtc_at = 0, k, c0;
    iba_space_e  sp_t [7] = '{SP_RAM, SP_RAM, SP_SYS, SP_SYS, SP_PSLOW,
                              SP_PSLOW, SP_PBUF};
    logic        wr_t [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    int          len_t [7] = '{RAM_CYC, RAM_CYC, SYS_RD_CYC, SYS_WR_CYC,
                               PER_RD_CYC, PER_WR_CYC, PBUF_WR_CYC};

    iba_arbiter u_iba_arbiter (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_div(periph_div),
        .cpu_req(cpu_req), .dtc_req(dtc_req), .dtc_no_yield(1'b0),
        .cpu_sleep(1'b0), .stby_req(stby_req), .clk_chg_req(1'b0),
        .sw_standby(sw_standby), .all_clk_stop(1'b0),
        .pin_input_buffer_enable(pin_ibe), .ext_release_request_in(req_n),
        .ext_cycle_busy(ext_busy), .cpu_ack(cpu_ack), .dtc_ack(dtc_ack),
        .ext_ack(), .acc_done(acc_done), .stby_go(stby_go), .clk_chg_go(),
        .release_ack_n_o(ack_n), .release_ack_oe(ack_oe),
        .bus_reclaim_request_out_o(rcl_n),
        .bus_reclaim_request_out_oe(rcl_oe), .ext_bus_oe(bus_oe));

    iba_ext_master u_iba_ext_master (
        .clock(clock), .want(want), .req_n(req_n));

    always #50 clock = ~clock;

    // Grants and retirements, numbered by cycle
    always @(negedge clock) begin
        cyc++;
        if (acc_done === 1'b1) dn = cyc;
        if (cpu_ack === 1'b1) begin
            cpu_acks++;
            cpu_at = cyc;
        end
        if (dtc_ack === 1'b1) begin
            dtc_acks++;
            dtc_at = cyc;
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic timeout();
        errors++;
        $display("BAD %0t wait ran out", $time);
        end_of_test();
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t bit %b want %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t word %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_num(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            errors++;
            $display("BAD %0t count %0d want %0d", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        logic rdy;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        rdy = 1'b0;
        for (i = 0; i < 20 && !rdy; i++) begin
            @(posedge clock);
            if (pready === 1'b1) begin
                rdy = 1'b1;
                rd = prdata;
                er = pslverr;
            end
        end
        if (!rdy) timeout();
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One access; k is the distance from grant to retirement
    task automatic go(input logic transfer_controller, input logic both, input iba_space_e sp,
                      input logic wr);
        int i;
        int n0;
        n0 = transfer_controller ? dtc_acks : cpu_acks;
        dn = -1;
        @(posedge clock);
        if (transfer_controller || both) dtc_req <= '{1'b1, wr, 1'b0, sp};
        if (!transfer_controller || both) cpu_req <= '{1'b1, wr, 1'b0, sp};
        for (i = 0; i < 40 && (transfer_controller ? dtc_acks : cpu_acks) == n0; i++)
            @(posedge clock);
        cpu_req <= '0;
        dtc_req <= '0;
        for (i = 0; i < 40 && dn < (transfer_controller ? dtc_at : cpu_at); i++)
            @(posedge clock);
        k = dn - (transfer_controller ? dtc_at : cpu_at);
        if (i == 40) timeout();
    endtask

    task automatic both_busy();
        c0 = cpu_acks;
        @(posedge clock);
        cpu_req <= '{1'b1, 1'b0, 1'b0, SP_RAM};
        dtc_req <= '{1'b1, 1'b0, 1'b0, SP_RAM};
        repeat (16) @(posedge clock);
        cpu_req <= '0;
        dtc_req <= '0;
        repeat (4) @(posedge clock);
    endtask

    task automatic wait_pin(input logic lvl);
        int i;
        @(negedge clock);
        for (i = 0; i < 20 && ack_n !== lvl; i++) @(negedge clock);
        if (i == 20) timeout();
        num_checks++;
    endtask

    task automatic do_reset();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (4) @(negedge clock);
        chk_bit(ack_n, 1'b1);
        chk_bit(bus_oe, 1'b1);
        @(posedge clock);
        rst_n <= 1'b1;
    endtask

    initial begin
        #(100 * 50000);
        timeout();
    end

    initial begin
        do_reset();
        apb(1'b1, 8'h00, 32'h1a);
        apb(1'b0, 8'h00, 32'h0);
        chk_word(rd, 32'h1a);
        apb(1'b1, 8'h04, 32'hf);
        apb(1'b0, 8'h04, 32'h0);
        chk_word(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk_bit(er, 1'b1);
        apb(1'b1, 8'h00, 32'h0);
        for (int j = 0; j < 7; j++) begin
            go(1'b0, 1'b0, sp_t[j], wr_t[j]);
            chk_num(k, len_t[j]);
        end
        @(posedge clock);
        periph_div <= 4'h3;
        go(1'b0, 1'b0, SP_PSLOW, 1'b0);
        chk_bit(k >= 2 && k <= 8, 1'b1);
        @(posedge clock);
        periph_div <= 4'h1;
        c0 = cpu_acks;
        go(1'b1, 1'b1, SP_RAM, 1'b0);
        chk_num(cpu_acks, c0);
        both_busy();
        chk_num(cpu_acks, c0);
        apb(1'b1, 8'h00, 32'h1);
        both_busy();
        chk_bit(cpu_acks > c0, 1'b1);
        // Release held off until the external cycle ends, then reclaim
        apb(1'b1, 8'h00, 32'h18);
        @(posedge clock);
        pin_ibe <= 1'b1;
        ext_busy <= 1'b1;
        want <= 1'b1;
        repeat (8) @(negedge clock);
        chk_bit(ack_n, 1'b1);
        @(posedge clock);
        ext_busy <= 1'b0;
        wait_pin(1'b0);
        chk_bit(bus_oe, 1'b0);
        chk_bit(ack_oe, 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        chk_bit(rd[3], 1'b1);
        c0 = cpu_acks;
        @(posedge clock);
        cpu_req <= '{1'b1, 1'b0, 1'b0, SP_EXT};
        stby_req <= 1'b1;
        repeat (4) @(negedge clock);
        chk_num(cpu_acks, c0);
        chk_bit(rcl_n, 1'b0);
        chk_bit(stby_go, 1'b0);
        @(posedge clock);
        want <= 1'b0;
        wait_pin(1'b1);
        chk_bit(bus_oe, 1'b1);
        repeat (6) @(negedge clock);
        chk_bit(cpu_acks > c0, 1'b1);
        chk_bit(stby_go, 1'b1);
        @(posedge clock);
        cpu_req <= '0;
        stby_req <= 1'b0;
        // Release enable off, then pin input buffer off
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, 8'h00, m ? 32'h10 : 32'h0);
            @(posedge clock);
            pin_ibe <= (m == 0);
            want <= 1'b1;
            repeat (8) @(negedge clock);
            chk_bit(ack_n, 1'b1);
            @(posedge clock);
            want <= 1'b0;
            repeat (4) @(negedge clock);
        end
        @(posedge clock);
        pin_ibe <= 1'b1;
        sw_standby <= 1'b1;
        want <= 1'b1;
        repeat (8) @(negedge clock);
        chk_bit(ack_oe, 1'b0);
        chk_bit(rcl_oe, 1'b0);
        @(posedge clock);
        sw_standby <= 1'b0;
        wait_pin(1'b0);
        do_reset();
        apb(1'b0, 8'h00, 32'h0);
        chk_word(rd, 32'h0);
        @(posedge clock);
        want <= 1'b0;
        end_of_test();
    end
endmodule // iba_arbiter_tb_top
`default_nettype wire
